/* src/hdsp_prefetcher.sv */
// Stream detector and prefetch issuer watching last-level cache misses
//
// Notes on behaviour
// - Stream starts only after two successive misses with stride below trigger distance.
// - Prefetches run up to 256 bytes ahead of the demand location.
// - At most one tracked stream per 4-KByte page, load or store.
// - Base variant holds up to 8 streams, each in its own page.
// - No prefetch ever crosses a 4-KByte boundary.
// - Prefetches target second or third level cache, never first level.
// - Uncacheable and write-combining targets are never prefetched.
// - Store streams issue ownership reads, load streams plain data reads.
// - Small variant targets second level, 12 forward and 4 backward streams.
// - Enlarged variant holds 16 forward and 4 backward streams.
// - Each core instantiates its own independent prefetcher.
// - Ascending and descending streams detected, prefetch follows direction.
// - Fully autonomous, no software control input.
`timescale 1ns/1ps

module hdsp_prefetcher #(
  parameter hdsp_pkg::hdsp_variant_t VARIANT         = hdsp_pkg::HDSP_VAR_BASE,
  parameter int unsigned             TRIG_DIST_BYTES = 512
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Observed last-level misses
  input  wire hdsp_pkg::hdsp_miss_t missIn,
  // Prefetch request path
  output hdsp_pkg::hdsp_req_t       pfReq,
  input  wire logic                 pfReqReady,
  // Occupancy
  output logic [hdsp_pkg::CNT_W-1:0] streamCount
);

  localparam int NE = hdsp_pkg::NUM_ENTRIES;
  localparam bit IS_BASE = (VARIANT == hdsp_pkg::HDSP_VAR_BASE);
  // Base variant shares one pool of streams; the others cap each direction
  localparam int FWD_CAP = (VARIANT == hdsp_pkg::HDSP_VAR_SMALL) ? hdsp_pkg::SMALL_FWD :
                           (VARIANT == hdsp_pkg::HDSP_VAR_LARGE) ? hdsp_pkg::LARGE_FWD :
                           hdsp_pkg::BASE_STREAMS;
  localparam int BWD_CAP = (VARIANT == hdsp_pkg::HDSP_VAR_SMALL) ? hdsp_pkg::SMALL_BWD :
                           (VARIANT == hdsp_pkg::HDSP_VAR_LARGE) ? hdsp_pkg::LARGE_BWD :
                           hdsp_pkg::BASE_STREAMS;
  localparam int TOTAL_CAP = IS_BASE ? hdsp_pkg::BASE_STREAMS : NE;
  localparam logic [1:0] TGT_LEVEL = IS_BASE ? hdsp_pkg::LVL_L3 : hdsp_pkg::LVL_L2;

  // Signed line index, so a backward pointer can fall below line zero
  typedef logic signed [hdsp_pkg::NXT_W-1:0] hdsp_off_t;

  // Address helpers
  function automatic logic [hdsp_pkg::PAGE_W-1:0] pageOf(input logic [hdsp_pkg::ADDR_W-1:0] a);
    pageOf = a[hdsp_pkg::ADDR_W-1:hdsp_pkg::PAGE_LSB];
  endfunction : pageOf

  function automatic logic [hdsp_pkg::LINE_OFF_W-1:0] lineOf(input logic [hdsp_pkg::ADDR_W-1:0] a);
    lineOf = a[hdsp_pkg::PAGE_LSB-1:hdsp_pkg::LINE_LSB];
  endfunction : lineOf

  function automatic hdsp_off_t widen(input logic [hdsp_pkg::LINE_OFF_W-1:0] l);
    widen = hdsp_off_t'({2'b00, l});
  endfunction : widen

  // One line further along the stream, either way
  function automatic hdsp_off_t stepLine(input hdsp_off_t l, input logic back);
    if (back) begin
      stepLine = l - hdsp_off_t'(1);
    end else begin
      stepLine = l + hdsp_off_t'(1);
    end
  endfunction : stepLine

  // Uncacheable and write-combining targets must never be fetched early
  function automatic logic isCacheable(input logic [2:0] mt);
    isCacheable = (mt != hdsp_pkg::MT_UNCACHEABLE) && (mt != hdsp_pkg::MT_WRITE_COMBINING);
  endfunction : isCacheable

  // Line address inside the stream's own page, so it cannot leave it
  function automatic logic [hdsp_pkg::ADDR_W-1:0] lineAddr(input logic [hdsp_pkg::PAGE_W-1:0] p,
                                                           input hdsp_off_t                   l);
    lineAddr = {p, l[hdsp_pkg::LINE_OFF_W-1:0], {hdsp_pkg::LINE_LSB{1'b0}}};
  endfunction : lineAddr

  // Next prefetch line lies inside the page and inside the lead window
  function automatic logic eligible(input hdsp_pkg::hdsp_stream_t s);
    hdsp_off_t n;
    hdsp_off_t d;
    n = hdsp_off_t'(s.nxt);
    d = widen(s.dmd);
    if (!s.valid) begin
      eligible = 1'b0;
    end else if (s.backward) begin
      eligible = (n >= 0) && ((d - n) <= hdsp_off_t'(hdsp_pkg::AHEAD_LINES));
    end else begin
      eligible = (n <= hdsp_off_t'(hdsp_pkg::PAGE_LAST_LINE)) &&
                 ((n - d) <= hdsp_off_t'(hdsp_pkg::AHEAD_LINES));
    end
  endfunction : eligible

  // State
  hdsp_pkg::hdsp_stream_t           ent_r [NE];
  hdsp_pkg::hdsp_stream_t           ent_nxt [NE];
  logic                             lastValid_r;
  logic                             lastValid_nxt;
  logic [hdsp_pkg::PAGE_W-1:0]      lastPage_r;
  logic [hdsp_pkg::PAGE_W-1:0]      lastPage_nxt;
  logic [hdsp_pkg::LINE_OFF_W-1:0]  lastLine_r;
  logic [hdsp_pkg::LINE_OFF_W-1:0]  lastLine_nxt;
  hdsp_pkg::hdsp_req_t              pfReq_r;
  hdsp_pkg::hdsp_req_t              pfReq_nxt;
  logic [hdsp_pkg::CNT_W-1:0]       streamCount_r;
  logic [hdsp_pkg::CNT_W-1:0]       streamCount_nxt;

  // Working signals
  logic                             hit;
  int unsigned                      hitIdx;
  logic                             cacheable;
  logic [hdsp_pkg::PAGE_W-1:0]      mPage;
  logic [hdsp_pkg::LINE_OFF_W-1:0]  mLine;
  hdsp_off_t                        delta;
  hdsp_off_t                        absDelta;
  logic                             strideOk;
  logic                             newBack;
  int unsigned                      fwdCnt;
  int unsigned                      bwdCnt;
  int unsigned                      totCnt;
  logic                             atCap;
  logic                             freeFound;
  int unsigned                      freeIdx;
  logic                             lruFound;
  int unsigned                      lruIdx;
  logic [hdsp_pkg::AGE_W-1:0]       lruAge;
  int unsigned                      vic;
  logic                             canVictim;
  logic [NE-1:0]                    touched;
  logic                             issued;
  int unsigned                      cnt;

  always_comb begin
    for (int i = 0; i < NE; i++) begin
      ent_nxt[i] = ent_r[i];
    end
    lastValid_nxt = lastValid_r;
    lastPage_nxt  = lastPage_r;
    lastLine_nxt  = lastLine_r;
    pfReq_nxt     = pfReq_r;
    touched       = '0;
    mPage         = pageOf(missIn.addr);
    mLine         = lineOf(missIn.addr);
    cacheable     = isCacheable(missIn.memType);

    // Page lookup, one stream per page
    hit    = 1'b0;
    hitIdx = 0;
    for (int i = 0; i < NE; i++) begin
      if (ent_r[i].valid && (ent_r[i].page == mPage) && !hit) begin
        hit    = 1'b1;
        hitIdx = i;
      end
    end

    // Stride qualification against the previous miss
    delta    = widen(mLine) - widen(lastLine_r);
    absDelta = delta[hdsp_pkg::NXT_W-1] ? -delta : delta;
    newBack  = delta[hdsp_pkg::NXT_W-1];
    strideOk = lastValid_r && (lastPage_r == mPage) && (delta != 0) &&
               ((32'(absDelta) * 32'(hdsp_pkg::LINE_BYTES)) < TRIG_DIST_BYTES);

    // Occupancy per direction
    fwdCnt = 0;
    bwdCnt = 0;
    for (int i = 0; i < NE; i++) begin
      if (ent_r[i].valid && ent_r[i].backward) begin
        bwdCnt = bwdCnt + 1;
      end else if (ent_r[i].valid) begin
        fwdCnt = fwdCnt + 1;
      end
    end
    totCnt = fwdCnt + bwdCnt;
    if (IS_BASE) begin
      atCap = (totCnt >= TOTAL_CAP);
    end else begin
      atCap = newBack ? (bwdCnt >= BWD_CAP) : (fwdCnt >= FWD_CAP);
    end

    // Victim choice: free slot below cap, else oldest eligible entry
    freeFound = 1'b0;
    freeIdx   = 0;
    lruFound  = 1'b0;
    lruIdx    = 0;
    lruAge    = hdsp_pkg::AGE_ZERO;
    for (int i = 0; i < NE; i++) begin
      if (!ent_r[i].valid && !freeFound) begin
        freeFound = 1'b1;
        freeIdx   = i;
      end
      // Base variant evicts any direction, the others only their own
      if (ent_r[i].valid && (IS_BASE || (ent_r[i].backward == newBack)) &&
          (!lruFound || (ent_r[i].age > lruAge))) begin
        lruFound = 1'b1;
        lruIdx   = i;
        lruAge   = ent_r[i].age;
      end
    end
    canVictim = (!atCap && freeFound) || (atCap && lruFound);
    vic       = (!atCap && freeFound) ? freeIdx : lruIdx;

    if (missIn.valid) begin
      // Every observed miss ages the table
      for (int i = 0; i < NE; i++) begin
        // Saturating, so an idle entry never wraps round to look recent
        if (ent_r[i].valid && (ent_r[i].age != hdsp_pkg::AGE_MAX)) begin
          ent_nxt[i].age = ent_r[i].age + 1'b1;
        end
      end
      if (hit && !cacheable) begin
        ent_nxt[hitIdx].valid = 1'b0;
        touched[hitIdx]       = 1'b1;
      end else if (hit) begin
        touched[hitIdx]       = 1'b1;
        ent_nxt[hitIdx].dmd   = mLine;
        ent_nxt[hitIdx].age   = hdsp_pkg::AGE_ZERO;
        ent_nxt[hitIdx].store = missIn.store;
        // Demand overtook the pointer: restart just past the demand line
        if (!ent_r[hitIdx].backward && (hdsp_off_t'(ent_r[hitIdx].nxt) <= widen(mLine))) begin
          ent_nxt[hitIdx].nxt = stepLine(widen(mLine), 1'b0);
        end
        if (ent_r[hitIdx].backward && (hdsp_off_t'(ent_r[hitIdx].nxt) >= widen(mLine))) begin
          ent_nxt[hitIdx].nxt = stepLine(widen(mLine), 1'b1);
        end
      end else if (cacheable && strideOk && canVictim) begin
        touched[vic]          = 1'b1;
        ent_nxt[vic].valid    = 1'b1;
        ent_nxt[vic].page     = mPage;
        ent_nxt[vic].backward = newBack;
        ent_nxt[vic].store    = missIn.store;
        ent_nxt[vic].dmd      = mLine;
        ent_nxt[vic].age      = hdsp_pkg::AGE_ZERO;
        ent_nxt[vic].nxt      = stepLine(widen(mLine), newBack);
      end
      // Remember this miss for the next stride check
      // A hit or an uncached miss clears training, so no stream spans it
      lastValid_nxt = cacheable && !hit;
      lastPage_nxt  = mPage;
      lastLine_nxt  = mLine;
    end

    // Prefetch issue, one request held until accepted
    // Accepted request leaves the slot free
    if (pfReq_r.valid && pfReqReady) begin
      pfReq_nxt.valid = 1'b0;
    end
    issued = 1'b0;
    if (!pfReq_r.valid || pfReqReady) begin
      for (int i = 0; i < NE; i++) begin
        // Entries written by this miss wait a cycle, so a pointer has one writer
        if (!issued && !touched[i] && eligible(ent_r[i])) begin
          issued              = 1'b1;
          pfReq_nxt.valid     = 1'b1;
          pfReq_nxt.addr      = lineAddr(ent_r[i].page, hdsp_off_t'(ent_r[i].nxt));
          pfReq_nxt.ownership = ent_r[i].store;
          pfReq_nxt.level     = TGT_LEVEL;
          ent_nxt[i].nxt      = stepLine(hdsp_off_t'(ent_r[i].nxt), ent_r[i].backward);
        end
      end
    end

    cnt = 0;
    for (int i = 0; i < NE; i++) begin
      if (ent_nxt[i].valid) begin
        cnt = cnt + 1;
      end
    end
    streamCount_nxt = hdsp_pkg::CNT_W'(cnt);
  end

  // No software enables: behaviour depends only on observed misses and request-path readiness
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NE; i++) begin
        ent_r[i] <= '0;
      end
      lastValid_r   <= 1'b0;
      lastPage_r    <= '0;
      lastLine_r    <= '0;
      pfReq_r       <= '0;
      streamCount_r <= '0;
    end else begin
      for (int i = 0; i < NE; i++) begin
        ent_r[i] <= ent_nxt[i];
      end
      lastValid_r   <= lastValid_nxt;
      lastPage_r    <= lastPage_nxt;
      lastLine_r    <= lastLine_nxt;
      pfReq_r       <= pfReq_nxt;
      streamCount_r <= streamCount_nxt;
    end
  end

  // One instance per core, no shared state
  assign pfReq       = pfReq_r;
  assign streamCount = streamCount_r;

endmodule : hdsp_prefetcher

/* src/hdsp_pkg.sv */
// Shared constants and types for the hardware data stream prefetcher
package hdsp_pkg;

  // Address layout
  localparam int ADDR_W     = 32;
  localparam int LINE_LSB   = 6;
  localparam int PAGE_LSB   = 12;
  localparam int LINE_OFF_W = PAGE_LSB - LINE_LSB;
  localparam int PAGE_W     = ADDR_W - PAGE_LSB;
  localparam int NXT_W      = LINE_OFF_W + 2;
  localparam int LINE_BYTES = 64;

  // Lead of prefetches over demand
  localparam int AHEAD_BYTES = 256;
  localparam int AHEAD_LINES = AHEAD_BYTES / LINE_BYTES;
  localparam int PAGE_LAST_LINE = (1 << LINE_OFF_W) - 1;

  // Stream table sizing
  localparam int NUM_ENTRIES  = 20;
  localparam int CNT_W        = 5;
  localparam int BASE_STREAMS = 8;
  localparam int SMALL_FWD    = 12;
  localparam int SMALL_BWD    = 4;
  localparam int LARGE_FWD    = 16;
  localparam int LARGE_BWD    = 4;

  // Recency ages
  localparam int              AGE_W    = 5;
  localparam logic [AGE_W-1:0] AGE_MAX  = 5'h1f;
  localparam logic [AGE_W-1:0] AGE_ZERO = 5'h00;

  // Memory types of an observed miss
  localparam logic [2:0] MT_UNCACHEABLE      = 3'h0;
  localparam logic [2:0] MT_WRITE_COMBINING  = 3'h1;

  // Target cache level codes
  localparam logic [1:0] LVL_L2 = 2'h2;
  localparam logic [1:0] LVL_L3 = 2'h3;

  typedef enum logic [1:0] {
    HDSP_VAR_BASE  = 2'h0,
    HDSP_VAR_SMALL = 2'h1,
    HDSP_VAR_LARGE = 2'h2
  } hdsp_variant_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              store;
    logic [2:0]        memType;
  } hdsp_miss_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              ownership;
    logic [1:0]        level;
  } hdsp_req_t;

  typedef struct packed {
    logic                  valid;
    logic [PAGE_W-1:0]     page;
    logic                  backward;
    logic                  store;
    logic [LINE_OFF_W-1:0] dmd;
    logic [NXT_W-1:0]      nxt;
    logic [AGE_W-1:0]      age;
  } hdsp_stream_t;

endpackage : hdsp_pkg

/* verif/hdsp_checker_sva.sv */
// Port assertions for the stream prefetcher
`timescale 1ns/1ps
module hdsp_checker_sva (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  // Misses and requests
  input wire hdsp_pkg::hdsp_miss_t       missIn,
  input wire hdsp_pkg::hdsp_req_t        pfReq,
  input wire logic                       pfReqReady,
  // Occupancy
  input wire logic [hdsp_pkg::CNT_W-1:0] streamCount
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  level_target_a: assert property (pfReq.valid |-> pfReq.level == hdsp_pkg::LVL_L3)
    else $error("prefetch not aimed at third level");
  line_align_a: assert property (pfReq.valid |-> pfReq.addr[5:0] == 6'h00)
    else $error("prefetch not line aligned");
  valid_hold_a: assert property (pfReq.valid && !pfReqReady |=> pfReq.valid)
    else $error("request dropped before taken");
  data_hold_a: assert property (pfReq.valid && !pfReqReady |=> $stable(pfReq.addr) && $stable(pfReq.ownership))
    else $error("request changed before taken");
  max_streams_a: assert property (streamCount <= 5'h08)
    else $error("too many streams");
  alloc_cause_a: assert property (streamCount > $past(streamCount) |->
    $past(missIn.valid) && $past(missIn.memType) > 3'h1) else $error("stream without cacheable miss");
  count_step_a: assert property (streamCount <= $past(streamCount) + 5'h01)
    else $error("more than one stream per miss");
  uc_noalloc_a: assert property (missIn.valid && missIn.memType <= 3'h1 |=>
    streamCount <= $past(streamCount)) else $error("stream from uncacheable miss");

  cover property (streamCount != 5'h00 && $past(streamCount) == 5'h00);
  cover property (pfReq.valid && pfReqReady && pfReq.ownership);
  cover property (pfReq.valid && !pfReqReady);
endmodule : hdsp_checker_sva

/* verif/hdsp_req_sink.sv */
// Request path model that takes prefetches, optionally stalling
`timescale 1ns/1ps
module hdsp_req_sink (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Request path
  input  wire hdsp_pkg::hdsp_req_t pfReq,
  output logic                     pfReqReady,
  // Stall mode
  input  wire logic                slow
);
  // Slow mode stalls one cycle after each acceptance
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfReqReady <= 1'b0;
    end else begin
      pfReqReady <= !slow || !(pfReqReady && pfReq.valid);
    end
  end
endmodule : hdsp_req_sink

/* verif/testbench.sv */
// Self-checking bench for the stream prefetcher
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("wrong value %0t %h %h", $time, a, b); end end
module testbench;
  logic                       core_clk;
  logic                       rst_n;
  hdsp_pkg::hdsp_miss_t       missIn;
  hdsp_pkg::hdsp_req_t        pfReq;
  logic                       pfReqReady;
  logic [hdsp_pkg::CNT_W-1:0] streamCount;
  logic                       slow;
  logic [32:0]                got[$];
  int                         n_errors;
  int                         num_checks;

  hdsp_prefetcher dut_u (.core_clk(core_clk), .rst_n(rst_n), .missIn(missIn), .pfReq(pfReq),
                         .pfReqReady(pfReqReady), .streamCount(streamCount));
  hdsp_req_sink sink_u (.core_clk(core_clk), .rst_n(rst_n), .pfReq(pfReq), .pfReqReady(pfReqReady), .slow(slow));

  always @(posedge core_clk) begin
    if (pfReq.valid && pfReqReady) begin
      got.push_back({pfReq.ownership, pfReq.addr});
      `CHK(pfReq.level, hdsp_pkg::LVL_L3)
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic pair(input logic [31:0] a, input logic [31:0] b, input logic st, input logic [2:0] mt);
    @(posedge core_clk);
    #1;
    missIn = '{1'b1, a, st, mt};
    @(posedge core_clk);
    #1;
    missIn = '{1'b1, b, st, mt};
    @(posedge core_clk);
    #1;
    missIn = '0;
  endtask : pair

  // Waits until the request path has been quiet for 8 cycles
  task automatic settle;
    int q;
    q = 0;
    for (int i = 0; i < 300 && q < 8; i++) begin
      @(posedge core_clk);
      #1;
      q = pfReq.valid ? 0 : q + 1;
    end
    if (q < 8) begin
      n_errors++;
      give_verdict();
    end
  endtask : settle

  task automatic check_run(input logic [31:0] first, input logic [31:0] step, input int n, input logic own,
                           input logic [4:0] cnt);
    logic [32:0] exp;
    settle();
    `CHK(got.size(), n)
    for (int i = 0; i < n && i < got.size(); i++) begin
      exp = {own, first + step * i};
      `CHK(got[i], exp)
    end
    `CHK(streamCount, cnt)
    got.delete();
  endtask : check_run

  task automatic t_dirs;
    pair(32'h0000_1000, 32'h0000_1040, 1'b0, 3'h2);
    check_run(32'h0000_1080, 32'h0000_0040, 4, 1'b0, 5'h01);
    slow = 1'b1;
    pair(32'h0000_5fc0, 32'h0000_5f80, 1'b1, 3'h2);
    check_run(32'h0000_5f40, 32'hffff_ffc0, 4, 1'b1, 5'h02);
    slow = 1'b0;
    $display("test directions done");
  endtask : t_dirs

  task automatic t_limits;
    pair(32'h0000_bf40, 32'h0000_bf80, 1'b0, 3'h2);
    check_run(32'h0000_bfc0, 32'h0000_0040, 1, 1'b0, 5'h03);
    pair(32'h0000_9000, 32'h0000_9040, 1'b0, 3'h0);
    pair(32'h0000_c000, 32'h0000_c040, 1'b0, 3'h1);
    check_run(32'h0000_0000, 32'h0000_0000, 0, 1'b0, 5'h03);
    pair(32'h0000_a000, 32'h0000_a200, 1'b0, 3'h2);
    check_run(32'h0000_0000, 32'h0000_0000, 0, 1'b0, 5'h03);
    pair(32'h0000_d000, 32'h0000_d1c0, 1'b0, 3'h2);
    check_run(32'h0000_d200, 32'h0000_0040, 4, 1'b0, 5'h04);
    $display("test limits done");
  endtask : t_limits

  task automatic t_table;
    logic [31:0] b;
    logic [4:0]  c;
    pair(32'h0000_1200, 32'h0000_1240, 1'b1, 3'h2);
    check_run(32'h0000_1280, 32'h0000_0040, 4, 1'b1, 5'h04);
    for (int k = 0; k < 8; k++) begin
      b = 32'h0002_0000 + 32'h0000_1000 * k;
      c = (k < 4) ? 5'h05 + 5'(k) : 5'h08;
      pair(b, b + 32'h0000_0040, 1'b0, 3'h2);
      check_run(b + 32'h0000_0080, 32'h0000_0040, 4, 1'b0, c);
    end
    // Oldest page of the new set survives, wide stride moves its demand and restarts its pointer just past it
    pair(32'h0002_0100, 32'h0002_0300, 1'b0, 3'h2);
    check_run(32'h0002_0340, 32'h0000_0040, 4, 1'b0, 5'h08);
    $display("test table done");
  endtask : t_table

  initial begin
    rst_n = 1'b0;
    slow = 1'b0;
    missIn = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `CHK(pfReq.valid, 1'b0)
    t_dirs();
    t_limits();
    t_table();
    give_verdict();
  end
endmodule : testbench

bind hdsp_prefetcher hdsp_checker_sva chk_u (.core_clk(core_clk), .rst_n(rst_n), .missIn(missIn), .pfReq(pfReq),
                                             .pfReqReady(pfReqReady), .streamCount(streamCount));
